// [logic/status_trig.sv]
// Status byte summary, service request enable and bus trigger handling
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Status query does not clear anything
// - Query returns bits 0-5, 7, master; 0-1 zero
// - Bit 7 summarises operation status
// - Master in bit 6; request-service follows it
// - Poll shows request-service instead of master
// - Master holds until unmasked causes clear
// - Bit 5 summarises standard event register
// - Bit 4 set while output buffer holds data
// - Bit 3 summarises questionable status
// - Bit 2 summarises device status
// - Trigger command equals group execute trigger
// - Trigger starts only on bus source, waiting
// - Other bus triggers are ignored
// - Triggers queued in input buffer, in order
// - Only enabled bits feed the master
// - Enable register reads bit 6 as zero
module status_trig (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Subordinate summaries
  input wire status_trig_pkg::summaries_t summaries_i,
  // Output buffer activity
  input wire logic ob_load_i,
  input wire logic ob_read_i,
  // Controller queries and enable write
  input wire logic query_i,
  input wire logic poll_i,
  input wire logic sre_read_i,
  input wire logic sre_write_i,
  input wire logic [7:0] sre_data_i,
  // Input buffer
  input wire logic msg_valid_i,
  input wire status_trig_pkg::msg_t msg_i,
  output logic msg_ready_o,
  // Trigger system
  input wire status_trig_pkg::trig_src_t trigger_source_select_i,
  input wire logic trig_waiting_i,
  output logic meas_start_o,
  // Other input passed on in order
  output logic cmd_valid_o,
  output logic [7:0] cmd_data_o,
  // Responses
  output logic resp_valid_o,
  output logic [7:0] resp_data_o,
  output logic [7:0] status_byte_o,
  output logic srq_o
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [7:0] with_bit6(input logic [7:0] b, input logic v);
    logic [7:0] r;
    r = b;
    r[status_trig_pkg::BIT_MASTER] = v;
    return r;
  endfunction

  function automatic logic is_trigger(input status_trig_pkg::msg_kind_t k);
    return (k == status_trig_pkg::MSG_TRG_CMD) || (k == status_trig_pkg::MSG_GROUP_TRIG);
  endfunction

  status_trig_pkg::state_t state;
  status_trig_pkg::state_t next_state;
  logic ib_empty;
  status_trig_pkg::msg_t head;
  logic [7:0] raw;
  localparam int IBUF_FILL_W = status_trig_pkg::IBUF_AW + 1;
  logic [IBUF_FILL_W-1:0] fill;
  logic trig_ok;

  assign ib_empty = (state.wr_ptr == state.rd_ptr);
  assign trig_ok = !ib_empty && is_trigger(head.kind) &&
    (trigger_source_select_i == status_trig_pkg::SRC_BUS) && trig_waiting_i;
  assign head = state.ibuf[state.rd_ptr[status_trig_pkg::IBUF_AW-1:0]];
  assign fill = state.wr_ptr - state.rd_ptr;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_state = state;
    next_state.meas_start = 1'b0;
    next_state.cmd_valid = 1'b0;
    next_state.resp_valid = 1'b0;

    if (sre_write_i) begin
      next_state.sre = sre_data_i;
    end

    // Output buffer occupancy; saturates rather than wraps
    if (ob_load_i && !ob_read_i && state.ob_count != status_trig_pkg::OB_MAX) begin
      next_state.ob_count = state.ob_count + status_trig_pkg::OB_ONE;
    end else if (ob_read_i && !ob_load_i && state.ob_count != '0) begin
      next_state.ob_count = state.ob_count - status_trig_pkg::OB_ONE;
    end

    raw = 8'h00;
    raw[status_trig_pkg::BIT_OPERATION] = summaries_i.operation_summary;
    raw[status_trig_pkg::BIT_EVENT] = summaries_i.event_summary;
    raw[status_trig_pkg::BIT_OUT_AVAIL] = (state.ob_count != '0);
    raw[status_trig_pkg::BIT_QUESTIONABLE] = summaries_i.questionable_summary;
    raw[status_trig_pkg::BIT_DEVICE] = summaries_i.device_condition_summary;
    // Master is a live level: it drops only when no enabled cause remains
    next_state.status_summary_byte = with_bit6(raw,
      |(raw & next_state.sre & ~status_trig_pkg::MASTER_MASK));
    next_state.rqs = next_state.status_summary_byte[status_trig_pkg::BIT_MASTER];

    // Queries only sample; nothing is cleared by reading
    if (query_i) begin
      next_state.resp_valid = 1'b1;
      next_state.resp_data = state.status_summary_byte;
    end else if (poll_i) begin
      next_state.resp_valid = 1'b1;
      next_state.resp_data = with_bit6(state.status_summary_byte, state.rqs);
    end else if (sre_read_i) begin
      next_state.resp_valid = 1'b1;
      next_state.resp_data = with_bit6(state.sre, 1'b0);
    end

    // Input buffer: one message drained per cycle, strictly in order
    if (!ib_empty) begin
      next_state.rd_ptr = state.rd_ptr + status_trig_pkg::PTR_ONE;
      if (is_trigger(head.kind)) begin
        next_state.meas_start = (trigger_source_select_i == status_trig_pkg::SRC_BUS)
          && trig_waiting_i;
      end else begin
        next_state.cmd_valid = 1'b1;
        next_state.cmd_data = head.data;
      end
    end
    if (msg_valid_i && state.in_ready) begin
      next_state.ibuf[state.wr_ptr[status_trig_pkg::IBUF_AW-1:0]] = msg_i;
      next_state.wr_ptr = state.wr_ptr + status_trig_pkg::PTR_ONE;
    end
    next_state.in_ready =
      ((next_state.wr_ptr - next_state.rd_ptr) != status_trig_pkg::IBUF_FULL);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign msg_ready_o = state.in_ready;
  assign meas_start_o = state.meas_start;
  assign cmd_valid_o = state.cmd_valid;
  assign cmd_data_o = state.cmd_data;
  assign resp_valid_o = state.resp_valid;
  assign resp_data_o = state.resp_data;
  assign status_byte_o = state.status_summary_byte;
  assign srq_o = state.rqs;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence trig_head_s;
    !ib_empty && is_trigger(head.kind);
  endsequence

  sequence trig_allowed_s;
    (trigger_source_select_i == status_trig_pkg::SRC_BUS) && trig_waiting_i;
  endsequence

  query_readout_a: assert property (query_i |=> resp_valid_o &&
      resp_data_o == $past(state.status_summary_byte))
    else $error("status query returned wrong byte");

  low_bits_zero_a: assert property ((state.status_summary_byte &
      status_trig_pkg::ZERO_BITS) == 8'h00)
    else $error("status bits 0-1 not zero");

  summary_bits_a: assert property (##1
      state.status_summary_byte[status_trig_pkg::BIT_OPERATION] ==
        $past(summaries_i.operation_summary) &&
      state.status_summary_byte[status_trig_pkg::BIT_EVENT] ==
        $past(summaries_i.event_summary) &&
      state.status_summary_byte[status_trig_pkg::BIT_QUESTIONABLE] ==
        $past(summaries_i.questionable_summary) &&
      state.status_summary_byte[status_trig_pkg::BIT_DEVICE] ==
        $past(summaries_i.device_condition_summary))
    else $error("summary bit mismatch");

  master_enable_a: assert property (state.status_summary_byte[6] ==
      |(state.status_summary_byte & state.sre & ~status_trig_pkg::MASTER_MASK))
    else $error("master summary not from enabled bits");

  master_hold_a: assert property ($fell(state.status_summary_byte[6]) |->
      (state.status_summary_byte & state.sre & ~status_trig_pkg::MASTER_MASK) == 8'h00)
    else $error("master dropped with enabled cause present");

  rqs_follows_a: assert property (srq_o == state.status_summary_byte[6])
    else $error("request-service differs from master");

  poll_reply_a: assert property (poll_i && !query_i |=>
      resp_data_o == with_bit6($past(state.status_summary_byte), $past(state.rqs)))
    else $error("poll reply wrong");

  out_avail_a: assert property (##1
      state.status_summary_byte[4] == ($past(state.ob_count) != 5'h00))
    else $error("output-available bit wrong");

  sre_bit6_a: assert property (sre_read_i && !query_i && !poll_i |=>
      resp_data_o == with_bit6($past(state.sre), 1'b0))
    else $error("enable readback bit 6 not zero");

  trig_start_a: assert property (trig_head_s ##0 trig_allowed_s |=> meas_start_o)
    else $error("allowed trigger did not start");

  trig_ignore_a: assert property (meas_start_o |-> $past(trig_ok))
    else $error("measurement started without allowed trigger");

  ibuf_order_a: assert property (!ib_empty && !is_trigger(head.kind) |=>
      cmd_valid_o && cmd_data_o == $past(head.data) &&
      state.rd_ptr == $past(state.rd_ptr) + status_trig_pkg::PTR_ONE)
    else $error("input buffer drained out of order");

  ibuf_fill_a: assert property (fill <= status_trig_pkg::IBUF_FULL)
    else $error("input buffer overfilled");

endmodule // status_trig

`default_nettype wire

// [logic/status_trig_pkg.sv]
// Shared constants and types for the status byte and bus trigger block
package status_trig_pkg;

  // ****************************************************
  // Status byte layout
  // ****************************************************
  localparam int BIT_OPERATION = 7;
  localparam int BIT_MASTER = 6;
  localparam int BIT_EVENT = 5;
  localparam int BIT_OUT_AVAIL = 4;
  localparam int BIT_QUESTIONABLE = 3;
  localparam int BIT_DEVICE = 2;
  localparam logic [7:0] ZERO_BITS = 8'h03;
  localparam logic [7:0] MASTER_MASK = 8'h40;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // ****************************************************
  // Buffers
  // ****************************************************
  localparam int IBUF_DEPTH = 4;
  localparam int IBUF_AW = 2;
  localparam logic [IBUF_AW:0] PTR_ONE = 3'h1;
  localparam logic [IBUF_AW:0] IBUF_FULL = 3'h4;
  localparam logic [4:0] OB_ONE = 5'h01;
  localparam logic [4:0] OB_MAX = 5'h1F;

  // ****************************************************
  // Messages and trigger source
  // ****************************************************
  typedef enum logic [1:0] {
    MSG_OTHER = 2'b00,
    MSG_TRG_CMD = 2'b01,
    MSG_GROUP_TRIG = 2'b10
  } msg_kind_t;

  typedef enum logic [1:0] {
    SRC_IMMEDIATE = 2'b00,
    SRC_BUS = 2'b01,
    SRC_EXTERNAL = 2'b10
  } trig_src_t;

  typedef struct packed {
    msg_kind_t kind;
    logic [7:0] data;
  } msg_t;

  typedef struct packed {
    logic operation_summary;
    logic event_summary;
    logic questionable_summary;
    logic device_condition_summary;
  } summaries_t;

  typedef struct packed {
    logic [7:0] status_summary_byte;
    logic [7:0] sre;
    logic rqs;
    logic [4:0] ob_count;
    msg_t [IBUF_DEPTH-1:0] ibuf;
    logic [IBUF_AW:0] wr_ptr;
    logic [IBUF_AW:0] rd_ptr;
    logic in_ready;
    logic resp_valid;
    logic [7:0] resp_data;
    logic meas_start;
    logic cmd_valid;
    logic [7:0] cmd_data;
  } state_t;

endpackage

// [bench/ctrl_model.sv]
// Remote controller model offering messages to the input buffer
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
  // Clock
  input wire logic clk_i,
  // Input buffer handshake
  input wire logic msg_ready_i,
  output logic msg_valid_o,
  output status_trig_pkg::msg_t msg_o
);
  status_trig_pkg::msg_t pend[$];
  logic taken;
  initial begin
    msg_valid_o = 1'b0;
    msg_o = '0;
    taken = 1'b0;
  end
  task automatic send(input status_trig_pkg::msg_kind_t k, input logic [7:0] d);
    pend.push_back('{kind: k, data: d});
  endtask
  // Offer holds until an edge samples ready high
  always @(posedge clk_i) taken <= msg_valid_o && msg_ready_i;
  always @(negedge clk_i) begin
    if (taken)
      pend.delete(0);
    if (pend.size() > 0) begin
      msg_valid_o = 1'b1;
      msg_o = pend[0];
    end else begin
      msg_valid_o = 1'b0;
      // Idle lines toggle, so stale data is never mistaken for an offer
      msg_o = status_trig_pkg::msg_t'(~msg_o);
    end
  end
endmodule // ctrl_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the status byte and bus trigger block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  status_trig_pkg::summaries_t summaries_i = '0;
  status_trig_pkg::trig_src_t src = status_trig_pkg::SRC_BUS;
  status_trig_pkg::msg_t msg_i;
  logic [2:0] rq = 3'h0;
  logic [1:0] ob = 2'h0;
  logic sre_wr = 1'b0;
  logic waiting = 1'b1;
  logic [7:0] sre_d = 8'h00;
  logic msg_valid_i, msg_ready_o, meas_start_o, cmd_valid_o, resp_valid_o, srq_o;
  logic [7:0] cmd_data_o, resp_data_o, status_byte_o;
  logic [8:0] ev[$];
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  status_trig DUT (.clk_i(clk_i), .rstn_i(rstn_i), .summaries_i(summaries_i),
    .ob_load_i(ob[1]), .ob_read_i(ob[0]), .query_i(rq[2]), .poll_i(rq[1]),
    .sre_read_i(rq[0]), .sre_write_i(sre_wr), .sre_data_i(sre_d),
    .msg_valid_i(msg_valid_i), .msg_i(msg_i), .msg_ready_o(msg_ready_o),
    .trigger_source_select_i(src), .trig_waiting_i(waiting),
    .meas_start_o(meas_start_o), .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o),
    .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
    .status_byte_o(status_byte_o), .srq_o(srq_o));
  ctrl_model ctl (.clk_i(clk_i), .msg_ready_i(msg_ready_o), .msg_valid_o(msg_valid_i),
    .msg_o(msg_i));
  always @(negedge clk_i) begin
    if (meas_start_o === 1'b1)
      ev.push_back(9'h100);
    if (cmd_valid_o === 1'b1)
      ev.push_back({1'b0, cmd_data_o});
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ask(input logic [2:0] which, input logic [7:0] exp);
    @(negedge clk_i) rq = which;
    // Response pulse stands only in the cycle after the taking edge
    @(negedge clk_i) rq = 3'h0;
    chk({resp_valid_o, resp_data_o}, {1'b1, exp});
  endtask
  task automatic sett(input logic [3:0] s);
    @(negedge clk_i) summaries_i = s;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic wr_sre(input logic [7:0] v);
    @(negedge clk_i) sre_wr = 1'b1;
    sre_d = v;
    @(negedge clk_i) sre_wr = 1'b0;
  endtask
  task automatic obp(input logic [1:0] v);
    @(negedge clk_i) ob = v;
    @(negedge clk_i) ob = 2'h0;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic t_bits();
    int p[4] = '{status_trig_pkg::BIT_OPERATION, status_trig_pkg::BIT_EVENT,
      status_trig_pkg::BIT_QUESTIONABLE, status_trig_pkg::BIT_DEVICE};
    for (int i = 0; i < 4; i++) begin
      sett(4'h8 >> i);
      chk(status_byte_o, 8'h01 << p[i]);
      ask(3'h4, 8'h01 << p[i]);
    end
    sett(4'hF);
    ask(3'h4, 8'hAC);
    $display("summary bit test done");
  endtask
  task automatic t_master();
    wr_sre(8'hFF);
    ask(3'h1, 8'hBF);
    wr_sre(8'h08);
    sett(4'h4);
    chk({srq_o, status_byte_o}, 9'h020);
    sett(4'h6);
    chk({srq_o, status_byte_o}, 9'h168);
    ask(3'h4, 8'h68);
    ask(3'h4, 8'h68);
    chk({srq_o, status_byte_o}, 9'h168);
    ask(3'h2, 8'h68);
    sett(4'h2);
    chk({srq_o, status_byte_o}, 9'h148);
    sett(4'h0);
    chk({srq_o, status_byte_o}, 9'h000);
    $display("master summary test done");
  endtask
  task automatic t_outbuf();
    wr_sre(8'h10);
    obp(2'h2);
    obp(2'h2);
    chk(status_byte_o, 8'h50);
    obp(2'h1);
    chk(status_byte_o, 8'h50);
    obp(2'h1);
    chk(status_byte_o, 8'h00);
    $display("output buffer test done");
  endtask
  task automatic t_trig();
    logic [8:0] exp[5] = '{9'h05A, 9'h100, 9'h100, 9'h0A5, 9'h03C};
    ev.delete();
    ctl.send(status_trig_pkg::MSG_OTHER, 8'h5A);
    ctl.send(status_trig_pkg::MSG_TRG_CMD, 8'h00);
    ctl.send(status_trig_pkg::MSG_GROUP_TRIG, 8'h00);
    ctl.send(status_trig_pkg::MSG_OTHER, 8'hA5);
    ctl.send(status_trig_pkg::MSG_OTHER, 8'h3C);
    repeat (20) @(negedge clk_i);
    chk(9'(ev.size()), 9'h005);
    for (int i = 0; i < 5 && i < ev.size(); i++)
      chk(ev[i], exp[i]);
    $display("bus trigger test done");
  endtask
  task automatic t_ignore();
    for (int k = 0; k < 3; k++) begin
      ev.delete();
      @(negedge clk_i) src = (k == 0) ? status_trig_pkg::SRC_IMMEDIATE :
        (k == 1) ? status_trig_pkg::SRC_EXTERNAL : status_trig_pkg::SRC_BUS;
      waiting = (k != 2);
      ctl.send(k[0] ? status_trig_pkg::MSG_TRG_CMD : status_trig_pkg::MSG_GROUP_TRIG, 8'h00);
      repeat (10) @(negedge clk_i);
      chk(9'(ev.size()), 9'h000);
    end
    $display("ignored trigger test done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({8'h00, msg_ready_o}, 9'h001);
    t_bits();
    t_master();
    t_outbuf();
    t_trig();
    t_ignore();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
